// ==== dcs_pkg.sv ====
// Package for the DMA controller status block: offsets, fields, reset values.
package dcs_pkg;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int ADDR_W = 16;
  // Register byte offsets
  localparam logic [11:0] OFF_COLLISION = 12'h000;
  localparam logic [11:0] OFF_ACTIVITY = 12'h004;
  localparam logic [11:0] OFF_LAST_ADDR = 12'h008;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h00C;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h010;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h014;
  // Field positions
  localparam int PWCOL_LSB = 8;
  localparam int RWCOL_LSB = 0;
  localparam int LAST_CH_LSB = 8;
  localparam int PP_LSB = 0;
  // Reset values
  localparam logic [3:0] LAST_CH_NONE = 4'hF;
  localparam logic [15:0] COLL_RST = 16'h0000;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] PP_RST = 8'h00;
  // Interrupt status bits
  localparam int IRQ_PWCOL = 0;
  localparam int IRQ_RWCOL = 1;
  localparam int IRQ_XFER = 2;
  localparam int IRQ_W = 3;
endpackage

// ==== dcs_status.sv ====
// DMA controller status logic: collision flags, last channel, ping-pong, last address.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps

//
// Contract
// - Per-channel peripheral write collision flag at bit 8+n, sticky until cleared.
// - Per-channel RAM write collision flag at bit n, sticky until cleared.
// - Second status register bits 11:8 hold last channel, reset to 1111.
// - Each completed transfer loads last channel with its binary channel number.
// - 1111 only before first transfer; codes 1000-1110 never produced.
// - Ping-pong bit n is 1 on secondary start address, 0 on primary; resets 0.
// - Sixteen-bit register captures latest RAM address accessed; resets zero.
// - Bits 15:12 of second status register read zero, writes ignored.
// - In ping-pong modes channel toggles buffer after each block.
module dcs_status (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic xfer_done_i,
  input wire logic [dcs_pkg::CH_W-1:0] xfer_ch_i,
  input wire logic [dcs_pkg::NUM_CH-1:0] periph_collide_i,
  input wire logic [dcs_pkg::NUM_CH-1:0] ram_collide_i,
  input wire logic [dcs_pkg::NUM_CH-1:0] block_done_i,
  input wire logic [dcs_pkg::NUM_CH-1:0] pingpong_mode_i,
  input wire logic ram_access_i,
  input wire logic [dcs_pkg::ADDR_W-1:0] ram_addr_i,
  output logic irq_o
);
  import dcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic wr_coll;
  logic wr_ien;
  logic wr_iclr;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign addr_ok = (paddr_i == OFF_COLLISION) || (paddr_i == OFF_ACTIVITY) ||
                   (paddr_i == OFF_LAST_ADDR) || (paddr_i == OFF_IRQ_STATUS) ||
                   (paddr_i == OFF_IRQ_ENABLE) || (paddr_i == OFF_IRQ_CLEAR);
  assign wr_coll = wr_en && (paddr_i == OFF_COLLISION);
  assign wr_ien = wr_en && (paddr_i == OFF_IRQ_ENABLE) && pstrb_i[0];
  assign wr_iclr = wr_en && (paddr_i == OFF_IRQ_CLEAR) && pstrb_i[0];
  // Zero-wait slave; unmapped addresses answer with an error
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Collision flags
  logic [15:0] coll_ff;
  logic [15:0] nxt_coll;
  logic [15:0] coll_set;
  logic [15:0] coll_keep;
  assign coll_set = {periph_collide_i, ram_collide_i};
  // Byte lane gating; a zero bit written clears, a one keeps
  assign coll_keep = wr_coll ? (pwdata_i[15:0] | {{8{!pstrb_i[1]}}, {8{!pstrb_i[0]}}})
                             : 16'hFFFF;
  // Set beats a simultaneous clear so no collision is lost
  assign nxt_coll = (coll_ff & coll_keep) | coll_set;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      coll_ff <= COLL_RST;
    end else begin
      coll_ff <= nxt_coll;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Last active channel
  logic [3:0] last_ch_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_ch_ff <= LAST_CH_NONE;
    end else if (xfer_done_i) begin
      // Zero-extended 3-bit code can never reach 1000-1111
      last_ch_ff <= {1'b0, xfer_ch_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ping-pong buffer select, one bit per channel
  logic [NUM_CH-1:0] pp_ff;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_pp
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pp_ff[gi] <= 1'b0;
        end else if (!pingpong_mode_i[gi]) begin
          // Outside ping-pong the channel always runs from the primary buffer
          pp_ff[gi] <= 1'b0;
        end else if (block_done_i[gi]) begin
          pp_ff[gi] <= !pp_ff[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Most recent RAM address
  logic [ADDR_W-1:0] last_addr_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_addr_ff <= ADDR_RST;
    end else if (ram_access_i) begin
      last_addr_ff <= ram_addr_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [IRQ_W-1:0] ist_ff;
  logic [IRQ_W-1:0] ien_ff;
  logic [IRQ_W-1:0] ev;
  assign ev[IRQ_PWCOL] = |periph_collide_i;
  assign ev[IRQ_RWCOL] = |ram_collide_i;
  assign ev[IRQ_XFER] = xfer_done_i;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ist_ff <= '0;
    end else if (wr_iclr) begin
      ist_ff <= (ist_ff & ~pwdata_i[IRQ_W-1:0]) | ev;
    end else begin
      ist_ff <= ist_ff | ev;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ien_ff <= '0;
    end else if (wr_ien) begin
      ien_ff <= pwdata_i[IRQ_W-1:0];
    end
  end
  assign irq_o = |(ist_ff & ien_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered on the setup phase
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (paddr_i)
      OFF_COLLISION: nxt_rdata = {16'h0000, coll_ff};
      // Upper bits of the activity word are unimplemented and read zero
      OFF_ACTIVITY: nxt_rdata = {20'h0_0000, last_ch_ff, pp_ff};
      OFF_LAST_ADDR: nxt_rdata = {16'h0000, last_addr_ff};
      OFF_IRQ_STATUS: nxt_rdata = {29'h0000_0000, ist_ff};
      OFF_IRQ_ENABLE: nxt_rdata = {29'h0000_0000, ien_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign prdata_o = rd_en ? rdata_ff : 32'h0000_0000;
endmodule

// ==== dcs_status_assertions.sv ====
// Checker for the DMA status block: read-back timing of events and bus refusals.
`timescale 1ns/1ps
module dcs_sva import dcs_pkg::*; (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire logic xfer_done_i,
  input wire logic [CH_W-1:0] xfer_ch_i,
  input wire logic [NUM_CH-1:0] periph_collide_i,
  input wire logic [NUM_CH-1:0] ram_collide_i,
  input wire logic [NUM_CH-1:0] pingpong_mode_i,
  input wire logic ram_access_i,
  input wire logic [ADDR_W-1:0] ram_addr_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Event two edges back lands in the register sampled at setup
  sequence rd(a); psel_i && penable_i && !pwrite_i && paddr_i == a; endsequence
  property rdp(a, c, v); rd(a) ##0 c |-> v; endproperty
  pcol_set_a: assert property (rdp(OFF_COLLISION, 1'b1,
    (prdata_o[15:8] & $past(periph_collide_i, 2)) == $past(periph_collide_i, 2)))
    else $error("peripheral collision flag not set");
  rcol_set_a: assert property (rdp(OFF_COLLISION, 1'b1,
    (prdata_o[7:0] & $past(ram_collide_i, 2)) == $past(ram_collide_i, 2)))
    else $error("ram collision flag not set");
  last_ch_a: assert property (rdp(OFF_ACTIVITY, $past(xfer_done_i, 2),
    prdata_o[11:8] == {1'b0, $past(xfer_ch_i, 2)})) else $error("last channel wrong");
  rsv_code_a: assert property (rdp(OFF_ACTIVITY, 1'b1,
    !prdata_o[11] || prdata_o[10:8] == 3'h7)) else $error("reserved channel code");
  hi_zero_a: assert property (rdp(OFF_ACTIVITY, 1'b1, prdata_o[15:12] == 4'h0))
    else $error("unimplemented bits not zero");
  pp_idle_a: assert property (rdp(OFF_ACTIVITY, $past(pingpong_mode_i, 2) == 8'h00,
    prdata_o[7:0] == 8'h00)) else $error("ping-pong bit set outside ping-pong mode");
  last_addr_a: assert property (rdp(OFF_LAST_ADDR, $past(ram_access_i, 2),
    prdata_o[15:0] == $past(ram_addr_i, 2))) else $error("last address wrong");
  unmapped_a: assert property (psel_i && penable_i && paddr_i > OFF_IRQ_CLEAR
    |-> pslverr_o && prdata_o == 32'h0000_0000) else $error("unmapped access accepted");
endmodule
bind dcs_status dcs_sva i_sva (.*);

// ==== dcs_eng.sv ====
// Stand-in for the channel engines: random transfer, collision and block events.
`timescale 1ns/1ps
module dcs_eng (
  input wire logic clk_i,
  input wire logic en_i,
  output logic [20:0] ev_o = 21'h00_0000,
  output logic [7:0] pcol_o = 8'h00,
  output logic [7:0] rcol_o = 8'h00,
  output logic [7:0] blk_o = 8'h00,
  output logic [7:0] mode_o = 8'h00
);
  always @(posedge clk_i) if (en_i) begin
    ev_o <= 21'($urandom);
    pcol_o <= 8'($urandom & $urandom & $urandom);
    rcol_o <= 8'($urandom & $urandom & $urandom);
    blk_o <= 8'($urandom & $urandom);
    // Modes change rarely so blocks alternate within a mode
    if ($urandom % 16 == 0) mode_o <= 8'($urandom);
  end
endmodule

// ==== dcs_status_tb.sv ====
// Self-checking bench for the DMA status block against a reference model.
`timescale 1ns/1ps
module dcs_status_tb;
  import dcs_pkg::*;
  logic clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, en = 0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [3:0] pstrb_i = 4'hF;
  wire logic [31:0] prdata_o;
  wire logic pready_o, pslverr_o, irq_o, xfer_done_i, ram_access_i;
  wire logic [2:0] xfer_ch_i;
  wire logic [7:0] periph_collide_i, ram_collide_i, block_done_i, pingpong_mode_i;
  wire logic [15:0] ram_addr_i;
  logic [15:0] mcol, maddr;
  logic [7:0] mpp;
  logic [3:0] mlc;
  logic [2:0] mst, men;
  int errors = 0, checks = 0;
  logic [11:0] offs [7] = '{OFF_COLLISION, OFF_ACTIVITY, OFF_LAST_ADDR, OFF_IRQ_STATUS,
    OFF_IRQ_ENABLE, OFF_IRQ_CLEAR, 12'h020};
  wire wr = psel_i && penable_i && pwrite_i;
  always #5 clk_i = ~clk_i;
  dcs_status i_dut (.*);
  dcs_eng i_eng (.clk_i, .en_i(en), .ev_o({xfer_done_i, xfer_ch_i, ram_access_i, ram_addr_i}),
    .pcol_o(periph_collide_i), .rcol_o(ram_collide_i), .blk_o(block_done_i),
    .mode_o(pingpong_mode_i));
  always @(posedge clk_i or negedge resetn_i) if (!resetn_i) begin
    {mcol, mlc, mpp, maddr, mst, men} = {COLL_RST, LAST_CH_NONE, PP_RST, ADDR_RST, 6'h00};
  end else begin
    // Byte lanes without a strobe leave their flags untouched
    if (wr && paddr_i == OFF_COLLISION)
      mcol = mcol & (pwdata_i[15:0] | ~{{8{pstrb_i[1]}}, {8{pstrb_i[0]}}});
    if (wr && paddr_i == OFF_IRQ_ENABLE && pstrb_i[0]) men = pwdata_i[2:0];
    if (wr && paddr_i == OFF_IRQ_CLEAR && pstrb_i[0]) mst = mst & ~pwdata_i[2:0];
    mcol = mcol | {periph_collide_i, ram_collide_i};
    mst = mst | {xfer_done_i, |ram_collide_i, |periph_collide_i};
    if (xfer_done_i) mlc = {1'b0, xfer_ch_i};
    mpp = (mpp ^ block_done_i) & pingpong_mode_i;
    if (ram_access_i) maddr = ram_addr_i;
  end
  function automatic logic [31:0] exp_rd(logic [11:0] a);
    case (a)
      OFF_COLLISION: return {16'h0000, mcol};
      OFF_ACTIVITY: return {20'h0_0000, mlc, mpp};
      OFF_LAST_ADDR: return {16'h0000, maddr};
      OFF_IRQ_STATUS: return {29'h0, mst};
      OFF_IRQ_ENABLE: return {29'h0, men};
      default: return 32'h0000_0000;
    endcase
  endfunction
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(bit w, logic [11:0] a, logic [31:0] d);
    logic [31:0] e;
    int n;
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= w ? 4'($urandom) : 4'h0;
    @(negedge clk_i) e = exp_rd(a);
    chk("irq", irq_o, |(mst & men));
    @(posedge clk_i) penable_i <= 1;
    n = 0;
    do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 20);
    // A wait that runs out counts as a mismatch here
    chk("pready", pready_o, 32'h0000_0001);
    if (!w) chk("rdata", prdata_o, e);
    chk("slverr", pslverr_o, a > OFF_IRQ_CLEAR);
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hcd42_d49f));
    repeat (16) @(posedge clk_i);
    resetn_i <= 1;
    @(posedge clk_i);
    foreach (offs[i]) apb(0, offs[i], 32'h0000_0000);
    en <= 1;
    // Random writes exercise clear-by-zero, masking and ignored read-only writes
    repeat (400) apb($urandom % 2, offs[$urandom % 7], $urandom);
    stop_test();
  end
  initial begin
    #100000;
    errors++;
    stop_test();
  end
endmodule
